// [rtl/hprc_pkg.sv]
package hprc_pkg;
  // Clock rate in Hz
  localparam int unsigned CLK_HZ = 40000000;
  // Hold and pulse times in milliseconds
  localparam int unsigned ON_HOLD_MS = 250;
  localparam int unsigned OFF_HOLD_MS = 4000;
  localparam int unsigned RST_HOLD_MS = 4000;
  localparam int unsigned PULSE_DEF_MS = 1000;
  localparam int unsigned OFF_EXTRA_MS = 5000;
  localparam int unsigned RST_PULSE_MS = 1000;
  // Millisecond tick divider
  localparam int unsigned MS_CYC = CLK_HZ / 1000;
  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_PULSE = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;
  // Control field positions
  localparam int CTRL_ON_EN = 0;
  localparam int CTRL_OFF_EN = 1;
  localparam int CTRL_RST_EN = 2;
  localparam int CTRL_PWR_INV = 3;
  localparam int CTRL_RST_INV = 4;
  localparam int CTRL_BLANK_EN = 5;
  // Reset values
  localparam logic [5:0] CTRL_RST_VAL = 6'h00;
  localparam logic [15:0] PULSE_RST_VAL = 16'h03e8;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_HOLD_ON, ST_HOLD_OFF, ST_HOLD_RST, ST_PWR_PULSE, ST_OFF_EXTRA, ST_RST_PULSE
  } hprc_state_t;
endpackage : hprc_pkg

// [rtl/hprc_hold_timer.sv]
`timescale 1ns/1ps
`default_nettype none
// Millisecond counter that restarts on clear and saturates
module hprc_hold_timer #(
  parameter int W = 16
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic tick, // One-cycle millisecond enable
  input wire logic clr, // Restart count at zero
  output logic [W-1:0] count // Elapsed milliseconds
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Next count, saturating so long holds never wrap
  always_comb begin
    cnt_d = cnt_q;
    if (clr) begin
      cnt_d = '0;
    end else if (tick && cnt_q != '1) begin
      cnt_d = cnt_q + W'(1);
    end
  end

  // Register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign count = cnt_q;
endmodule : hprc_hold_timer
`default_nettype wire

// [rtl/hprc_top.sv]
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module hprc_top
  import hprc_pkg::*;
#(
  parameter int unsigned MS_DIV = MS_CYC,
  parameter int unsigned ON_HOLD = ON_HOLD_MS,
  parameter int unsigned OFF_HOLD = OFF_HOLD_MS,
  parameter int unsigned RST_HOLD = RST_HOLD_MS,
  parameter int unsigned OFF_EXTRA = OFF_EXTRA_MS,
  parameter int unsigned RST_PULSE = RST_PULSE_MS
) (
  input wire logic pclk, // 40 MHz clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic pwr_sense, // Host switched supply sense
  input wire logic key_confirm, // Confirm key, high pressed
  input wire logic key_cancel, // Cancel key, high pressed
  input wire logic wdog_reset, // Watchdog reset request level
  input wire logic [7:0] fan_cfg, // Fan setting from fan block
  output logic pwr_sw_o, // Power switch drive level
  output logic pwr_sw_oe, // Power switch drive enable
  output logic rst_sw_o, // Reset switch drive level
  output logic rst_sw_oe, // Reset switch drive enable
  output logic disp_blank, // Display blanking
  output logic [7:0] fan_out, // Fan setting held toward fans
  output logic self_restart // One-cycle self restart pulse
);
  // Refuse timings the divider or the 16-bit timer cannot serve
  if (MS_DIV < 2 || ON_HOLD < 1 || OFF_HOLD < 1 || RST_HOLD < 1 || RST_PULSE < 1 || ON_HOLD > 65535 ||
      OFF_HOLD > 65535 || RST_HOLD > 65535 || OFF_EXTRA > 65535 || RST_PULSE > 65535) begin : g_bad_param
    $error("hprc_top: timing parameters out of range");
  end

  localparam int DW = $clog2(MS_DIV);

  logic [DW-1:0] div_q, div_d; // Millisecond divider
  logic tick_q, tick_d; // Millisecond enable
  logic [5:0] ctrl_q, ctrl_d; // Control register
  logic [15:0] pulse_q, pulse_d; // Power pulse width in ms
  logic [31:0] prdata_q, prdata_d; // Read data
  logic pready_q, pready_d; // Ready
  logic pslverr_q, pslverr_d; // Error
  hprc_state_t st_q, st_d; // Sequencer state
  logic tclr; // Restart hold timer
  logic [15:0] tcount; // Hold timer value
  logic pwr_drv_q, pwr_drv_d; // Power line driven
  logic kp_rst_q, kp_rst_d; // Keypad reset driven
  logic rst_oe_q, rst_oe_d; // Reset line driven
  logic pwr_o_q, rst_o_q; // Drive levels
  logic blank_q, blank_d; // Blanking
  logic [7:0] fan_q, fan_d; // Held fan setting
  logic restart_q, restart_d; // Restart pulse
  logic acc; // APB access phase

  assign acc = psel && penable;

  // Divider: one tick per millisecond
  always_comb begin
    div_d = div_q + DW'(1);
    tick_d = 1'b0;
    if (div_q == DW'(MS_DIV - 1)) begin
      div_d = '0;
      tick_d = 1'b1;
    end
  end

  // APB slave, zero wait states, unmapped reads zero with error
  always_comb begin
    ctrl_d = ctrl_q;
    pulse_d = pulse_q;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (psel && !penable) begin
      pready_d = 1'b1;
      prdata_d = '0;
      unique case (paddr)
        ADDR_CTRL: begin
          prdata_d = {26'h0, ctrl_q};
        end
        ADDR_PULSE: begin
          prdata_d = {16'h0000, pulse_q};
        end
        ADDR_STAT: begin
          prdata_d = {26'h0, rst_oe_q, pwr_drv_q, blank_q, key_cancel, key_confirm, pwr_sense};
        end
        default: begin
          pslverr_d = 1'b1;
        end
      endcase
    end
    // Software sets each enable and polarity
    // A write lands only at the edge that samples pready high
    if (acc && pready_q && pwrite) begin
      if (paddr == ADDR_CTRL) begin
        ctrl_d = pwdata[5:0];
      end
      if (paddr == ADDR_PULSE) begin
        pulse_d = (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
      end
    end
  end

  // Shared hold and pulse timer
  hprc_hold_timer #(.W(16)) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick_q),
    .clr(tclr),
    .count(tcount)
  );

  // Keypad sequencer
  always_comb begin
    st_d = st_q;
    tclr = 1'b0;
    restart_d = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
        tclr = 1'b1;
        if (!pwr_sense && key_confirm && ctrl_q[CTRL_ON_EN]) begin
          st_d = ST_HOLD_ON;
        end else if (pwr_sense && key_cancel && ctrl_q[CTRL_OFF_EN]) begin
          st_d = ST_HOLD_OFF;
        end else if (pwr_sense && key_confirm && ctrl_q[CTRL_RST_EN]) begin
          st_d = ST_HOLD_RST;
        end
      end
      ST_HOLD_ON: begin
        if (!key_confirm || pwr_sense || !ctrl_q[CTRL_ON_EN]) begin
          st_d = ST_IDLE;
        end else if (tcount >= 16'(ON_HOLD)) begin
          st_d = ST_PWR_PULSE;
          tclr = 1'b1;
        end
      end
      ST_HOLD_OFF: begin
        if (!key_cancel || !pwr_sense || !ctrl_q[CTRL_OFF_EN]) begin
          st_d = ST_IDLE;
        end else if (tcount >= 16'(OFF_HOLD)) begin
          st_d = ST_PWR_PULSE;
          tclr = 1'b1;
        end
      end
      ST_HOLD_RST: begin
        if (!key_confirm || !pwr_sense || !ctrl_q[CTRL_RST_EN]) begin
          st_d = ST_IDLE;
        end else if (tcount >= 16'(RST_HOLD)) begin
          st_d = ST_RST_PULSE;
          tclr = 1'b1;
        end
      end
      ST_PWR_PULSE: begin
        if (tcount >= pulse_q) begin
          tclr = 1'b1;
          st_d = key_cancel ? ST_OFF_EXTRA : ST_IDLE;
        end
      end
      ST_OFF_EXTRA: begin
        if (!key_cancel || tcount >= 16'(OFF_EXTRA)) begin
          st_d = ST_IDLE;
        end
      end
      ST_RST_PULSE: begin
        if (tcount >= 16'(RST_PULSE)) begin
          st_d = ST_IDLE;
          restart_d = 1'b1;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // Pin drive and side outputs
  always_comb begin
    pwr_drv_d = (st_d == ST_PWR_PULSE) || (st_d == ST_OFF_EXTRA);
    kp_rst_d = (st_d == ST_RST_PULSE);
    // one path for keypad and watchdog
    rst_oe_d = kp_rst_d || wdog_reset;
    blank_d = ctrl_q[CTRL_BLANK_EN] && !pwr_sense;
    // fans keep setting while host off
    fan_d = pwr_sense ? fan_cfg : fan_q;
  end

  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
      tick_q <= 1'b0;
      ctrl_q <= CTRL_RST_VAL;
      pulse_q <= PULSE_RST_VAL;
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      st_q <= ST_IDLE;
      pwr_drv_q <= 1'b0;
      kp_rst_q <= 1'b0;
      rst_oe_q <= 1'b0;
      pwr_o_q <= 1'b0;
      rst_o_q <= 1'b0;
      blank_q <= 1'b0;
      fan_q <= 8'h00;
      restart_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
      ctrl_q <= ctrl_d;
      pulse_q <= pulse_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      st_q <= st_d;
      pwr_drv_q <= pwr_drv_d;
      kp_rst_q <= kp_rst_d;
      rst_oe_q <= rst_oe_d;
      // Asserted level follows polarity bit
      pwr_o_q <= ctrl_d[CTRL_PWR_INV];
      rst_o_q <= ctrl_d[CTRL_RST_INV];
      blank_q <= blank_d;
      fan_q <= fan_d;
      restart_q <= restart_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pwr_sw_o = pwr_o_q;
  assign pwr_sw_oe = pwr_drv_q;
  assign rst_sw_o = rst_o_q;
  assign rst_sw_oe = rst_oe_q;
  assign disp_blank = blank_q;
  assign fan_out = fan_q;
  assign self_restart = restart_q;

  // Helper: cycles the keypad reset has been driven
  logic [31:0] rst_cyc_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cyc_q <= '0;
    end else begin
      rst_cyc_q <= kp_rst_q ? rst_cyc_q + 32'd1 : 32'd0;
    end
  end

  // power line driven only by a pulse state
  a_pwr_drive_src: assert property (@(posedge pclk) disable iff (!presetn)
    pwr_sw_oe |-> (st_q == ST_PWR_PULSE || st_q == ST_OFF_EXTRA))
    else $error("power line driven outside pulse");
  // reset line only from keypad or watchdog
  a_rst_drive_src: assert property (@(posedge pclk) disable iff (!presetn)
    rst_sw_oe |-> $past(kp_rst_d || wdog_reset))
    else $error("reset line driven without cause");
  // watchdog reaches the reset line next cycle
  a_wdog_shares: assert property (@(posedge pclk) disable iff (!presetn)
    wdog_reset |=> rst_sw_oe)
    else $error("watchdog reset not driven");
  // on-hold needs sense low and confirm
  a_on_start: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_HOLD_ON && st_d == ST_PWR_PULSE) |-> (key_confirm && !pwr_sense))
    else $error("power on without hold");
  // forced off enters pulse only after hold
  a_off_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_HOLD_OFF && st_d == ST_PWR_PULSE) |-> tcount >= 16'(OFF_HOLD))
    else $error("forced off too early");
  a_extra_end: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_OFF_EXTRA && !key_cancel) |=> st_q == ST_IDLE)
    else $error("extension outlived key");
  // restart pulse follows reset pulse end
  a_restart: assert property (@(posedge pclk) disable iff (!presetn)
    self_restart |-> $past(st_q == ST_RST_PULSE) && st_q == ST_IDLE)
    else $error("restart without reset pulse");
  a_enable_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_IDLE && !ctrl_q[CTRL_RST_EN]) |=> st_q != ST_HOLD_RST)
    else $error("reset hold while disabled");
  // blank tracks sense one cycle later
  a_blank: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q[CTRL_BLANK_EN] && !pwr_sense) |=> disp_blank)
    else $error("display not blanked");
  a_fan_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !pwr_sense |=> $stable(fan_out))
    else $error("fan changed while host off");
  a_release: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_HOLD_ON && !key_confirm) |=> (st_q == ST_IDLE && !pwr_sw_oe))
    else $error("release did not cancel");
  // sense high never starts power on
  a_sense_on: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_IDLE && pwr_sense) |=> st_q != ST_HOLD_ON)
    else $error("power on while host on");
  a_rst_len: assert property (@(posedge pclk) disable iff (!presetn)
    kp_rst_q |-> rst_cyc_q <= 32'(RST_PULSE * MS_DIV))
    else $error("keypad reset pulse too long");
endmodule : hprc_top
`default_nettype wire

// [sim/hprc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Motherboard switch inputs: pulled up, measures each press
module hprc_host_model (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic pwr_sw_o, // Power drive level
  input wire logic pwr_sw_oe, // Power drive enable
  input wire logic rst_sw_o, // Reset drive level
  input wire logic rst_sw_oe, // Reset drive enable
  output logic pwr_pin, // Resolved power pin
  output logic rst_pin, // Resolved reset pin
  output logic done, // One cycle: press ended
  output logic kind, // 0 power, 1 reset
  output logic lvl, // Level seen while driven
  output logic [15:0] width // Press length in cycles
);
  logic [15:0] cnt_q; // Running press length
  // dedicated lines
  // Released pins float to the board pull-up, not the last level
  assign pwr_pin = pwr_sw_oe ? pwr_sw_o : 1'b1;
  assign rst_pin = rst_sw_oe ? rst_sw_o : 1'b1;
  // Press measurement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      done <= 1'b0;
      kind <= 1'b0;
      lvl <= 1'b0;
      width <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (pwr_sw_oe || rst_sw_oe) begin
        cnt_q <= cnt_q + 16'h0001;
        kind <= rst_sw_oe;
        lvl <= rst_sw_oe ? rst_pin : pwr_pin;
      end else if (cnt_q != 16'h0000) begin
        // Report once the press is over
        done <= 1'b1;
        width <= cnt_q;
        cnt_q <= 16'h0000;
      end
    end
  end
endmodule : hprc_host_model
`default_nettype wire

// [sim/host_power_reset_control_test.sv]
`timescale 1ns/1ps
`default_nettype none
module host_power_reset_control_test;
  import hprc_pkg::*;
  typedef struct {logic k; logic l; int c; int t;} hprc_note_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, pwr_sense = 0, key_confirm = 0, key_cancel = 0, wdog_reset = 0;
  logic [7:0] fan_cfg = 8'h00, fan_out, fh;
  logic pwr_sw_o, pwr_sw_oe, rst_sw_o, rst_sw_oe, disp_blank, self_restart;
  logic pwr_pin, rst_pin, done, kind, lvl;
  logic [15:0] width;
  int errors = 0, samples_checked = 0, restarts = 0, seed = 32'h3e67f31f;
  hprc_note_t q[$]; // Expected presses, oldest first
  hprc_note_t nt;
  wire busy = pwr_sw_oe | rst_sw_oe; // Any line driven
  always #12.5 pclk = ~pclk; // 40 MHz
  // Short counts keep the run small: 1 ms is 4 cycles
  hprc_top #(.MS_DIV(4), .ON_HOLD(3), .OFF_HOLD(5), .RST_HOLD(5), .OFF_EXTRA(6), .RST_PULSE(4)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwr_sense(pwr_sense),
    .key_confirm(key_confirm), .key_cancel(key_cancel), .wdog_reset(wdog_reset), .fan_cfg(fan_cfg),
    .pwr_sw_o(pwr_sw_o), .pwr_sw_oe(pwr_sw_oe), .rst_sw_o(rst_sw_o), .rst_sw_oe(rst_sw_oe),
    .disp_blank(disp_blank), .fan_out(fan_out), .self_restart(self_restart));
  hprc_host_model host (.pclk(pclk), .presetn(presetn), .pwr_sw_o(pwr_sw_o), .pwr_sw_oe(pwr_sw_oe),
    .rst_sw_o(rst_sw_o), .rst_sw_oe(rst_sw_oe), .pwr_pin(pwr_pin), .rst_pin(rst_pin), .done(done),
    .kind(kind), .lvl(lvl), .width(width));
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // APB cycle; waits for pready under a bound
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) begin
      errors++;
      $display("ERROR apb timeout");
      end_sim;
    end
  endtask : apb
  task rchk(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk("prdata", e, rd);
    chk("pslverr", {31'h0, ee}, {31'h0, er});
  endtask : rchk
  // Bounded wait for the drive lines to reach a level
  task wait_busy(input logic v);
    int n;
    n = 0;
    while (busy !== v && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) begin
      errors++;
      $display("ERROR drive wait timeout");
      end_sim;
    end
  endtask : wait_busy
  // Hold a key until a press appears; release at its start or end
  task act(input logic cancel, input logic early);
    if (cancel) key_cancel <= 1'b1;
    else key_confirm <= 1'b1;
    wait_busy(1'b1);
    if (early) {key_confirm, key_cancel} <= 2'b00;
    wait_busy(1'b0);
    {key_confirm, key_cancel} <= 2'b00;
    @(posedge pclk);
  endtask : act
  // Result watcher: each finished press against the oldest note
  always @(posedge pclk) begin
    if (self_restart === 1'b1) restarts++;
    if (done === 1'b1) begin
      if (q.size() == 0) chk("unexpected_press", 0, 1);
      else begin
        nt = q.pop_front();
        chk("press_kind", nt.k, kind);
        chk("press_level", nt.l, lvl);
        chk("width_in_tol", 1, (width + nt.t >= nt.c) && (width <= nt.c + nt.t));
      end
    end
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(ADDR_CTRL, 32'h0, 1'b0);
    rchk(ADDR_PULSE, 32'h3e8, 1'b0);
    rchk(12'h00c, 32'h0, 1'b1);
    apb(1'b1, ADDR_PULSE, 32'h3);
    rchk(ADDR_PULSE, 32'h3, 1'b0);
    $display("test registers done");
    // Host off, power on enabled, drive low, blanking on
    apb(1'b1, ADDR_CTRL, 32'h21);
    repeat (2) @(posedge pclk);
    chk("disp_blank", 1, disp_blank);
    rchk(ADDR_STAT, 32'h8, 1'b0);
    q.push_back('{1'b0, 1'b0, 12, 4});
    act(1'b0, 1'b1);
    key_confirm <= 1'b1;
    repeat (8) @(posedge pclk);
    key_confirm <= 1'b0;
    repeat (30) @(posedge pclk);
    $display("test power on done");
    apb(1'b1, ADDR_CTRL, 32'h0);
    key_confirm <= 1'b1;
    repeat (30) @(posedge pclk);
    key_confirm <= 1'b0;
    // Host on, forced off enabled, drive high
    pwr_sense <= 1'b1;
    fan_cfg <= 8'($random(seed));
    apb(1'b1, ADDR_CTRL, 32'h0a);
    chk("fan_out", fan_cfg, fan_out);
    q.push_back('{1'b0, 1'b1, 36, 5});
    act(1'b1, 1'b0);
    q.push_back('{1'b0, 1'b1, 12, 4});
    act(1'b1, 1'b1);
    key_confirm <= 1'b1;
    repeat (30) @(posedge pclk);
    key_confirm <= 1'b0;
    $display("test forced off done");
    apb(1'b1, ADDR_CTRL, 32'h14);
    q.push_back('{1'b1, 1'b1, 16, 4});
    act(1'b0, 1'b1);
    repeat (3) @(posedge pclk);
    chk("restarts", 1, restarts);
    apb(1'b1, ADDR_CTRL, 32'h0);
    q.push_back('{1'b1, 1'b0, 10, 1});
    wdog_reset <= 1'b1;
    repeat (10) @(posedge pclk);
    wdog_reset <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("restarts", 1, restarts);
    $display("test reset done");
    // Host off: display blank, fans keep their setting
    apb(1'b1, ADDR_CTRL, 32'h20);
    pwr_sense <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("disp_blank", 1, disp_blank);
    fh = fan_out;
    fan_cfg <= ~fan_out;
    // Random cancel while off and disabled must start nothing
    key_cancel <= 1'($random(seed));
    repeat (3) @(posedge pclk);
    chk("fan_hold", fh, fan_out);
    key_cancel <= 1'b0;
    pwr_sense <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("disp_blank", 0, disp_blank);
    chk("notes_left", 0, q.size());
    $display("test host off done");
    end_sim;
  end
endmodule : host_power_reset_control_test
`default_nettype wire
